// file: hbis_dev.sv
// Device end: strap decode, parallel strobe decode, serial pin mapping, frame sync
`default_nettype none
module hbis_dev
  import hbis_pkg::*;
#(
  parameter int FRAME_CYC = HBIS_FRAME_CYC  // Frame sync period in clocks
) (
  input  wire logic       clk_sys,          // System clock
  input  wire logic       rst_n,            // Synchronous reset, active low
  hbis_if.dev             bus,              // Pins toward host
  input  wire logic [7:0] status_byte,      // Status returned on command reads
  input  wire logic [7:0] ram_rd_byte,      // Display RAM read word
  input  wire logic       int_osc_tick,     // Internal oscillator tick level
  output logic            wr_cmd_pulse,     // Command byte written
  output logic            wr_data_pulse,    // Display data byte written
  output logic [7:0]      wr_byte,          // Byte written
  output logic            ram_rd_pulse,     // Display RAM read advanced
  output logic [2:0]      mode,             // Decoded mode
  output logic            addr_lsb,         // I2C address lsb
  output logic            disp_clk_level    // Selected display clock level
);
  import hbis_pkg::*;
  // Decoded combinational views
  wire hbis_mode_t m_w      = hbis_decode(bus.bus_select_straps);
  wire        sel_w         = !bus.cs_n;
  wire        rst_all_w     = !rst_n || !bus.reset_n;
  wire        is_en_w       = (m_w == HBIS_MODE_ENSTB);
  wire        is_sep_w      = (m_w == HBIS_MODE_SEPSTB);
  wire        is_spi_w      = (m_w == HBIS_MODE_SPI4) || (m_w == HBIS_MODE_SPI3);
  wire        sclk_w        = bus.data_bus[HBIS_SCLK_BIT];
  wire        serial_data_in_w        = bus.data_bus[HBIS_SERIAL_DATA_IN_BIT];
  // Registers
  logic       en_q_reg;          // Previous enable level
  logic       rd_q_reg;          // Previous read strobe level
  logic       wr_q_reg;          // Previous write strobe level
  logic       sclk_q_reg;        // Previous serial clock level
  logic [7:0] rd_pipe_reg;       // Pipelined RAM read byte
  logic [2:0] bitcnt_reg;        // Serial bit count
  logic [7:0] shift_reg;         // Serial shift register
  logic       drive_reg;         // Bus drive active
  logic [7:0] dout_reg;          // Byte on the bus
  logic [$clog2(FRAME_CYC)-1:0] frame_cnt_reg;  // Frame counter
  logic       frame_reg;         // Frame sync level
  // Edge detects
  wire en_fall_w  = is_en_w && en_q_reg && !bus.en_rd && sel_w;
  wire en_act_w   = is_en_w && bus.en_rd && sel_w;
  wire en_rd_w    = en_act_w && bus.rw_wr;
  wire sep_rd_w   = is_sep_w && sel_w && !bus.en_rd && bus.rw_wr;
  wire sep_rd_end = is_sep_w && sel_w && !rd_q_reg && bus.en_rd;
  wire sep_wr_w   = is_sep_w && sel_w && !bus.rw_wr;
  wire sep_wr_end = is_sep_w && sel_w && !wr_q_reg && bus.rw_wr;
  wire sclk_rise  = is_spi_w && sel_w && !sclk_q_reg && sclk_w;
  // Write strobe of any parallel style, direction low means write
  wire par_wr_w   = (en_fall_w && !bus.rw_wr) || sep_wr_end;
  // Read end of any parallel style
  wire par_rd_w   = (en_fall_w && bus.rw_wr) || sep_rd_end;
  wire spi_done_w = sclk_rise && (bitcnt_reg == 3'h7);
  wire [7:0] spi_byte_w = {shift_reg[6:0], serial_data_in_w};
  // Read byte: display data through pipeline, status on command reads
  wire [7:0] rd_sel_w = bus.dc ? rd_pipe_reg : status_byte;
  // Strobe history
  always_ff @(posedge clk_sys) begin
    if (rst_all_w) begin
      en_q_reg   <= 1'b0;
      rd_q_reg   <= 1'b1;
      wr_q_reg   <= 1'b1;
      sclk_q_reg <= 1'b1;  // Pulled-up idle level, no false edge after reset
    end else begin
      en_q_reg   <= bus.en_rd;
      rd_q_reg   <= bus.en_rd;
      wr_q_reg   <= bus.rw_wr;
      sclk_q_reg <= sclk_w;
    end
  end
  // Write capture, parallel and serial
  always_ff @(posedge clk_sys) begin
    if (rst_all_w) begin
      wr_cmd_pulse  <= 1'b0;
      wr_data_pulse <= 1'b0;
      wr_byte       <= HBIS_BYTE_RST;
    end else if (par_wr_w) begin
      wr_cmd_pulse  <= !bus.dc;
      wr_data_pulse <= bus.dc;
      wr_byte       <= bus.data_bus;
    end else if (spi_done_w) begin
      // Three-wire relies on dc tied low, so all bytes go to command
      wr_cmd_pulse  <= !bus.dc;
      wr_data_pulse <= bus.dc;
      wr_byte       <= spi_byte_w;
    end else begin
      wr_cmd_pulse  <= 1'b0;
      wr_data_pulse <= 1'b0;
    end
  end
  // Serial shifter, reset by chip select high
  always_ff @(posedge clk_sys) begin
    if (rst_all_w || !sel_w) begin
      bitcnt_reg <= 3'h0;
      shift_reg  <= HBIS_BYTE_RST;
    end else if (sclk_rise) begin
      bitcnt_reg <= bitcnt_reg + 3'h1;
      shift_reg  <= spi_byte_w;
    end
  end
  // Read pipeline: each display read returns the previous fetch
  always_ff @(posedge clk_sys) begin
    if (rst_all_w) begin
      rd_pipe_reg  <= HBIS_BYTE_RST;
      ram_rd_pulse <= 1'b0;
    end else begin
      ram_rd_pulse <= par_rd_w && bus.dc;
      if (par_rd_w && bus.dc)
        rd_pipe_reg <= ram_rd_byte;
    end
  end
  // Bus drive only during a selected read
  always_ff @(posedge clk_sys) begin
    if (rst_all_w) begin
      drive_reg <= 1'b0;
      dout_reg  <= HBIS_BYTE_RST;
    end else begin
      // Never drive while a write strobe is low
      drive_reg <= (en_rd_w || sep_rd_w) && !sep_wr_w;
      dout_reg  <= rd_sel_w;
    end
  end
  assign bus.d_do   = dout_reg;
  assign bus.d_oe_n = {HBIS_DW{!drive_reg}};
  // Frame sync toggles once per frame period
  always_ff @(posedge clk_sys) begin
    if (rst_all_w) begin
      frame_cnt_reg <= '0;
      frame_reg     <= 1'b0;
    end else if (frame_cnt_reg == ($clog2(FRAME_CYC))'(FRAME_CYC - 1)) begin
      frame_cnt_reg <= '0;
      frame_reg     <= !frame_reg;
    end else begin
      frame_cnt_reg <= frame_cnt_reg + 1'b1;
    end
  end
  assign bus.frame_sync_out = frame_reg;
  // Status outputs
  always_ff @(posedge clk_sys) begin
    if (rst_all_w) begin
      mode           <= 3'h0;
      addr_lsb       <= 1'b0;
      disp_clk_level <= 1'b0;
    end else begin
      mode           <= m_w;
      addr_lsb       <= (m_w == HBIS_MODE_I2C) ? bus.dc : 1'b0;
      disp_clk_level <= bus.clock_source_sel ? int_osc_tick : bus.ext_clock_in;
    end
  end
endmodule // hbis_dev
`default_nettype wire

// file: hbis_host.sv
// Host end: straps, reset, strobe sequencing for parallel writes and reads
`default_nettype none
module hbis_host
  import hbis_pkg::*;
(
  input  wire logic       clk_sys,        // System clock
  input  wire logic       rst_n,          // Synchronous reset, active low
  hbis_if.host            bus,            // Pins toward device
  input  wire logic [2:0] strap_cfg,      // Mode straps to apply
  input  wire logic       clk_src_cfg,    // Clock source strap
  input  wire logic       dev_reset_req,  // Hold device in reset
  input  wire logic       req,            // Start a transfer, one cycle
  input  wire logic       req_rd,         // High read, low write
  input  wire logic       req_dc,         // High data, low command
  input  wire logic [7:0] req_byte,       // Byte to write
  output logic            busy,           // Transfer in progress
  output logic            done,           // Transfer finished, one cycle
  output logic [7:0]      rd_byte         // Byte read
);
  import hbis_pkg::*;
  typedef enum logic [1:0] {HBIS_H_IDLE, HBIS_H_STB, HBIS_H_SER, HBIS_H_END} hbis_hst_t;
  hbis_hst_t  st_reg;        // Sequencer state
  logic [1:0] cnt_reg;       // Strobe width count
  logic       rd_reg;        // Current direction
  logic       dc_reg;        // Current data/command
  logic [7:0] byte_reg;      // Current write byte, shifts out msb first in serial
  logic [3:0] ser_cnt_reg;   // Serial half-bit count
  logic       ext_clk_reg;   // External clock stand-in
  wire hbis_mode_t m_w = hbis_decode(strap_cfg);
  wire is_en_w  = (m_w == HBIS_MODE_ENSTB);
  wire stb_on_w = (st_reg == HBIS_H_STB);
  wire sel_w    = (st_reg != HBIS_H_IDLE);
  wire spi3_w   = (m_w == HBIS_MODE_SPI3);
  wire is_spi_w  = (m_w == HBIS_MODE_SPI4) || spi3_w;            // Either serial mode
  wire is_i2c_w  = (m_w == HBIS_MODE_I2C);                        // Bus protocol not built
  wire ser_clk_w = (st_reg == HBIS_H_SER) && ser_cnt_reg[0];      // Serial clock level
  // Sequencer: select, strobe for a few clocks, release
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_reg   <= HBIS_H_IDLE;
      cnt_reg  <= 2'h0;
      ser_cnt_reg <= 4'h0;
      rd_reg   <= 1'b0;
      dc_reg   <= 1'b0;
      byte_reg <= HBIS_BYTE_RST;
      done     <= 1'b0;
      busy     <= 1'b0;
      rd_byte  <= HBIS_BYTE_RST;
    end else begin
      done <= 1'b0;
      case (st_reg)
        HBIS_H_IDLE: if (req) begin
          st_reg      <= is_spi_w ? HBIS_H_SER : HBIS_H_STB;
          cnt_reg     <= 2'h0;
          ser_cnt_reg <= 4'h0;
          rd_reg   <= req_rd;
          dc_reg   <= req_dc;
          byte_reg <= req_byte;
          busy     <= 1'b1;
        end
        HBIS_H_STB: begin
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == 2'(HBIS_STB_CYC)) begin
            st_reg  <= HBIS_H_END;
            rd_byte <= bus.data_bus;
          end
        end
        // Serial write: one clock low, one clock high per bit, msb first
        HBIS_H_SER: begin
          ser_cnt_reg <= ser_cnt_reg + 4'h1;
          if (ser_cnt_reg[0])
            byte_reg <= {byte_reg[6:0], 1'b0};
          if (&ser_cnt_reg)
            st_reg <= HBIS_H_END;
        end
        HBIS_H_END: begin
          st_reg <= HBIS_H_IDLE;
          busy   <= 1'b0;
          done   <= 1'b1;
        end
        default: st_reg <= HBIS_H_IDLE;
      endcase
    end
  end
  // External clock toggles each cycle when selected, held low otherwise
  always_ff @(posedge clk_sys) begin
    if (!rst_n || clk_src_cfg)
      ext_clk_reg <= 1'b0;
    else
      ext_clk_reg <= !ext_clk_reg;
  end
  // Pin drive
  assign bus.bus_select_straps = strap_cfg;
  assign bus.clock_source_sel  = clk_src_cfg;
  assign bus.ext_clock_in      = ext_clk_reg;
  assign bus.reset_n           = !dev_reset_req;
  assign bus.cs_n              = !sel_w;
  assign bus.dc                = spi3_w ? 1'b0 : dc_reg;
  // Enable style: enable high pulse, direction level; separate style: active-low strobes
  assign bus.en_rd = is_en_w ? stb_on_w : !(stb_on_w && rd_reg);
  assign bus.rw_wr = is_en_w ? (sel_w && rd_reg) : !(stb_on_w && !rd_reg);
  // Serial drives bit one data and bit zero clock only, bit two left open
  assign bus.h_do   = is_spi_w ? {6'h00, byte_reg[7], ser_clk_w} : byte_reg;
  assign bus.h_oe_n = is_spi_w ? {6'h3F, !sel_w, !sel_w} :
                      (is_i2c_w ? 8'hFF : {HBIS_DW{!(sel_w && !rd_reg)}});
endmodule // hbis_host
`default_nettype wire

// file: hbis_if.sv
// Interface carrying the host bus pins between host end and device end
`default_nettype none
interface hbis_if;
  logic [2:0] bus_select_straps;  // Mode straps
  logic       cs_n;               // Chip select, active low
  logic       dc;                 // Data high, command low; addr_lsb in I2C
  logic       en_rd;              // Enable (enable-strobe) or read strobe low
  logic       rw_wr;              // Direction (enable-strobe) or write strobe low
  logic       reset_n;            // Device reset, active low
  logic       clock_source_sel;   // High selects internal oscillator
  logic       ext_clock_in;       // External clock request level
  logic [7:0] h_do;               // Host data out
  logic [7:0] h_oe_n;             // Host output enable, low drives
  logic [7:0] d_do;               // Device data out
  logic [7:0] d_oe_n;             // Device output enable, low drives
  logic       frame_sync_out;     // Frame sync from device
  // Resolved bus level, pulled high when undriven
  wire  [7:0] data_bus;
  genvar i;
  for (i = 0; i < 8; i++) begin : g_res
    assign data_bus[i] = !h_oe_n[i] ? h_do[i] : (!d_oe_n[i] ? d_do[i] : 1'b1);
  end
  modport host (output bus_select_straps, cs_n, dc, en_rd, rw_wr, reset_n, clock_source_sel,
                output ext_clock_in, h_do, h_oe_n, input data_bus, frame_sync_out);
  modport dev  (input bus_select_straps, cs_n, dc, en_rd, rw_wr, reset_n, clock_source_sel,
                input ext_clock_in, data_bus, output d_do, d_oe_n, frame_sync_out);
endinterface
`default_nettype wire

// file: hbis_pkg.sv
// Package with mode, strap and timing constants for the host bus interface select block
`default_nettype none
package hbis_pkg;
  // Decoded interface modes
  typedef enum logic [2:0] {
    HBIS_MODE_I2C,
    HBIS_MODE_ENSTB,
    HBIS_MODE_SEPSTB,
    HBIS_MODE_SPI4,
    HBIS_MODE_SPI3,
    HBIS_MODE_BAD
  } hbis_mode_t;
  // Strap codes, bit order {bit2, bit1, bit0}
  localparam logic [2:0] HBIS_STRAP_I2C    = 3'h2;
  localparam logic [2:0] HBIS_STRAP_ENSTB  = 3'h4;
  localparam logic [2:0] HBIS_STRAP_SEPSTB = 3'h6;
  localparam logic [2:0] HBIS_STRAP_SPI4   = 3'h0;
  localparam logic [2:0] HBIS_STRAP_SPI3   = 3'h1;
  // Bus width and serial pin positions
  localparam int         HBIS_DW           = 8;
  localparam int         HBIS_SCLK_BIT     = 0;
  localparam int         HBIS_SERIAL_DATA_IN_BIT     = 1;
  localparam int         HBIS_SDAOUT_BIT   = 2;
  // Values after reset
  localparam logic [7:0] HBIS_STATUS_RST   = 8'h00;
  localparam logic [7:0] HBIS_BYTE_RST     = 8'h00;
  // Frame sync period in clocks and host strobe width less one, in clocks
  localparam int         HBIS_FRAME_CYC    = 1024;
  localparam int         HBIS_STB_CYC      = 2;
  // Strap to mode decode
  function automatic hbis_mode_t hbis_decode(input logic [2:0] s);
    case (s)
      HBIS_STRAP_I2C:    hbis_decode = HBIS_MODE_I2C;
      HBIS_STRAP_ENSTB:  hbis_decode = HBIS_MODE_ENSTB;
      HBIS_STRAP_SEPSTB: hbis_decode = HBIS_MODE_SEPSTB;
      HBIS_STRAP_SPI4:   hbis_decode = HBIS_MODE_SPI4;
      HBIS_STRAP_SPI3:   hbis_decode = HBIS_MODE_SPI3;
      default:           hbis_decode = HBIS_MODE_BAD;
    endcase
  endfunction
endpackage
`default_nettype wire

// file: hbis_properties.sv
// Concurrent checks on the host bus pins between host end and device end
`default_nettype none
module hbis_properties
  import hbis_pkg::*;
#(
  parameter int FRAME_CYC = HBIS_FRAME_CYC  // Frame sync period in clocks
) (
  input wire logic       clk_sys,            // System clock
  input wire logic       rst_n,              // Synchronous reset, active low
  input wire logic [2:0] bus_select_straps,  // Mode straps
  input wire logic       cs_n,               // Chip select
  input wire logic       en_rd,              // Enable or read strobe
  input wire logic       rw_wr,              // Direction or write strobe
  input wire logic       reset_n,            // Device reset pin
  input wire logic [7:0] h_oe_n,             // Host output enables
  input wire logic [7:0] d_oe_n,             // Device output enables
  input wire logic       frame_sync_out      // Frame sync from device
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire         par_en  = bus_select_straps == HBIS_STRAP_ENSTB;   // Enable-strobe mode
  wire         par_sep = bus_select_straps == HBIS_STRAP_SEPSTB;  // Separate-strobe mode
  logic        frame_q;                                          // Last frame level
  logic [15:0] gap_cnt;                                          // Clocks since last toggle
  logic        gap_seen;                                         // A toggle seen since reset
  wire         frame_chg = frame_sync_out != frame_q;            // Toggle this cycle
  // Measure spacing of frame sync toggles, restart on either reset
  always_ff @(posedge clk_sys) begin
    frame_q <= frame_sync_out;
    if (!rst_n || !reset_n) begin
      frame_q  <= 1'b0;
      gap_cnt  <= 16'h0000;
      gap_seen <= 1'b0;
    end else if (frame_chg) begin
      gap_cnt  <= 16'h0001;
      gap_seen <= 1'b1;
    end else begin
      gap_cnt <= gap_cnt + 16'h0001;
    end
  end
  a_bus_idle_release: assert property (cs_n && $past(cs_n) |-> d_oe_n == 8'hFF)
    else $error("device drives bus while deselected");
  a_no_bus_contention: assert property (h_oe_n != 8'hFF |-> d_oe_n == 8'hFF)
    else $error("device drives bus during host write");
  a_en_read_drive: assert property (par_en && !cs_n && en_rd && rw_wr && $past(en_rd) |-> d_oe_n == 8'h00)
    else $error("enable read does not drive bus");
  a_sep_read_drive: assert property (par_sep && !cs_n && !en_rd && $past(!en_rd) |-> d_oe_n == 8'h00)
    else $error("read strobe does not drive bus");
  a_sep_read_end: assert property (par_sep && en_rd && $past(en_rd) |-> d_oe_n == 8'hFF)
    else $error("bus held after read strobe rose");
  a_en_write_quiet: assert property (par_en && !rw_wr && $past(!rw_wr) |-> d_oe_n == 8'hFF)
    else $error("device drives bus with direction low");
  a_serial_pins_quiet: assert property (!(par_en || par_sep) && $past(!(par_en || par_sep))
    |-> {d_oe_n[7:3], d_oe_n[1:0]} == 7'h7F)
    else $error("parallel pins driven outside parallel modes");
  a_dev_reset_release: assert property (!reset_n |=> d_oe_n == 8'hFF)
    else $error("bus not released by device reset");
  a_frame_period: assert property (gap_seen && frame_chg |-> gap_cnt == 16'(FRAME_CYC))
    else $error("frame sync toggle spacing wrong");
  a_frame_not_stuck: assert property (gap_seen |-> gap_cnt <= 16'(FRAME_CYC))
    else $error("frame sync toggle overdue");
endmodule // hbis_properties
`default_nettype wire

// file: hbis_testbench.sv
// Self-checking bench joining host end and device end over the host bus
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import hbis_pkg::*;
  localparam int FC = 16;                      // Short frame period for simulation
  logic       clk_sys = 1'b0;                  // System clock
  logic       rst_n = 1'b0;                    // Reset, active low
  logic [2:0] strap_cfg = HBIS_STRAP_ENSTB;    // Strap setting
  logic       clk_src_cfg = 1'b1;              // Clock source strap
  logic       dev_reset_req = 1'b0;            // Device reset request
  logic       req = 1'b0;                      // Transfer request
  logic       req_rd = 1'b0;                   // Read when high
  logic       req_dc = 1'b0;                   // Data when high
  logic [7:0] req_byte = 8'h00;                // Byte to write
  logic [7:0] status_byte = 8'h5A;             // Status fed to device
  logic [7:0] ram_rd_byte = 8'hC3;             // RAM word fed to device
  logic       int_osc_tick = 1'b0;             // Internal oscillator level
  logic       busy, done, wr_cmd_pulse, wr_data_pulse, ram_rd_pulse, addr_lsb, disp_clk_level;
  logic [7:0] rd_byte, wr_byte;                // Read and written bytes
  logic [2:0] mode;                            // Decoded mode
  int         n_errors = 0, compares = 0, cyc = 0, n_cmd, n_dat, n_done, n_rdp, n_busy;
  hbis_if bus_if ();
  hbis_host hbis_host_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus_if), .strap_cfg(strap_cfg),
    .clk_src_cfg(clk_src_cfg), .dev_reset_req(dev_reset_req), .req(req), .req_rd(req_rd),
    .req_dc(req_dc), .req_byte(req_byte), .busy(busy), .done(done), .rd_byte(rd_byte));
  hbis_dev #(.FRAME_CYC(FC)) hbis_dev_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus_if),
    .status_byte(status_byte), .ram_rd_byte(ram_rd_byte), .int_osc_tick(int_osc_tick),
    .wr_cmd_pulse(wr_cmd_pulse), .wr_data_pulse(wr_data_pulse), .wr_byte(wr_byte),
    .ram_rd_pulse(ram_rd_pulse), .mode(mode), .addr_lsb(addr_lsb), .disp_clk_level(disp_clk_level));
  hbis_properties #(.FRAME_CYC(FC)) hbis_properties_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .bus_select_straps(bus_if.bus_select_straps), .cs_n(bus_if.cs_n), .en_rd(bus_if.en_rd),
    .rw_wr(bus_if.rw_wr), .reset_n(bus_if.reset_n), .h_oe_n(bus_if.h_oe_n), .d_oe_n(bus_if.d_oe_n),
    .frame_sync_out(bus_if.frame_sync_out));
  // Clock at 50 MHz
  always #10 clk_sys = ~clk_sys;
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      $display("MISMATCH t=%0t run timed out", $time);
      wrap_up();
    end
  end
  // Compare one value and count it
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Reset both ends with given straps, two cycles low
  task automatic do_reset(input logic [2:0] s);
    rst_n = 1'b0;
    strap_cfg = s;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
  endtask
  // One host transfer, counting device write pulses and host done
  task automatic xfer(input logic rd, input logic dc, input logic [7:0] b);
    @(negedge clk_sys);
    req = 1'b1;
    req_rd = rd;
    req_dc = dc;
    req_byte = b;
    n_cmd = 0;
    n_dat = 0;
    n_done = 0;
    n_rdp = 0;
    n_busy = 0;
    // Long enough for a serial byte of sixteen half bits
    repeat (20) begin
      @(negedge clk_sys);
      req = 1'b0;
      if (wr_cmd_pulse === 1'b1) n_cmd++;
      if (wr_data_pulse === 1'b1) n_dat++;
      if (done === 1'b1) n_done++;
      if (ram_rd_pulse === 1'b1) n_rdp++;
      if (busy === 1'b1) n_busy++;
    end
  endtask
  // Every strap code decodes to its mode; a bad code does nothing
  task automatic t_modes();
    logic [2:0] s_tab [6] = '{HBIS_STRAP_I2C, HBIS_STRAP_ENSTB, HBIS_STRAP_SEPSTB,
                              HBIS_STRAP_SPI4, HBIS_STRAP_SPI3, 3'h7};
    hbis_mode_t m_tab [6] = '{HBIS_MODE_I2C, HBIS_MODE_ENSTB, HBIS_MODE_SEPSTB,
                              HBIS_MODE_SPI4, HBIS_MODE_SPI3, HBIS_MODE_BAD};
    for (int i = 0; i < 6; i++) begin
      do_reset(s_tab[i]);
      check({5'h00, mode}, {5'h00, m_tab[i]});
    end
    xfer(1'b0, 1'b1, 8'h77);
    check(8'(n_cmd + n_dat), 8'h00);
    $display("test modes done");
  endtask
  // Writes, status read and pipelined display reads in one parallel style
  task automatic t_parallel(input logic [2:0] s);
    do_reset(s);
    xfer(1'b0, 1'b0, 8'h3C);
    check(8'(n_cmd), 8'h01);
    check(8'(n_dat), 8'h00);
    check(wr_byte, 8'h3C);
    check(8'(n_done), 8'h01);
    check(8'(n_busy), 8'(HBIS_STB_CYC + 2));
    xfer(1'b0, 1'b1, 8'hA5);
    check(8'(n_dat), 8'h01);
    check(wr_byte, 8'hA5);
    xfer(1'b1, 1'b0, 8'hFF);
    check(rd_byte, 8'h5A);
    check(8'(n_cmd + n_dat), 8'h00);
    check(8'(n_rdp), 8'h00);
    xfer(1'b1, 1'b1, 8'hFF);
    check(rd_byte, HBIS_BYTE_RST);
    check(8'(n_rdp), 8'h01);
    xfer(1'b1, 1'b1, 8'hFF);
    check(rd_byte, 8'hC3);
    check(wr_byte, 8'hA5);
    $display("test parallel %0h done", s);
  endtask
  // Clock strap picks internal tick or external input
  task automatic t_clock_src();
    clk_src_cfg = 1'b1;
    int_osc_tick = 1'b1;
    repeat (3) @(negedge clk_sys);
    check({7'h00, disp_clk_level}, 8'h01);
    int_osc_tick = 1'b0;
    repeat (3) @(negedge clk_sys);
    check({7'h00, disp_clk_level}, 8'h00);
    clk_src_cfg = 1'b0;
    int_osc_tick = 1'b1;
    repeat (3) @(negedge clk_sys);
    // External pin toggles every clock, so the registered level is one behind
    check({7'h00, disp_clk_level}, {7'h00, !bus_if.ext_clock_in});
    @(negedge clk_sys);
    check({7'h00, disp_clk_level}, {7'h00, !bus_if.ext_clock_in});
    $display("test clock source done");
  endtask
  // Device reset pin clears state, then traffic and frame sync resume
  task automatic t_dev_reset();
    int n;
    logic prev;
    dev_reset_req = 1'b1;
    repeat (3) @(negedge clk_sys);
    check(wr_byte, HBIS_BYTE_RST);
    dev_reset_req = 1'b0;
    repeat (3) @(negedge clk_sys);
    xfer(1'b0, 1'b1, 8'h81);
    check(8'(n_dat), 8'h01);
    n = 0;
    prev = bus_if.frame_sync_out;
    repeat (4 * FC) begin
      @(negedge clk_sys);
      if (bus_if.frame_sync_out !== prev) n++;
      prev = bus_if.frame_sync_out;
    end
    check(8'(n), 8'h04);
    $display("test device reset and frame done");
  endtask
  // Serial writes msb first in both serial modes, then address bit in bus mode
  task automatic t_serial();
    do_reset(HBIS_STRAP_SPI4);
    xfer(1'b0, 1'b1, 8'h96);
    check(8'(n_dat), 8'h01);
    check(8'(n_cmd), 8'h00);
    check(wr_byte, 8'h96);
    xfer(1'b0, 1'b0, 8'h4B);
    check(8'(n_cmd), 8'h01);
    check(wr_byte, 8'h4B);
    do_reset(HBIS_STRAP_SPI3);
    xfer(1'b0, 1'b1, 8'h69);
    check(8'(n_cmd), 8'h01);
    check(wr_byte, 8'h69);
    do_reset(HBIS_STRAP_I2C);
    xfer(1'b0, 1'b1, 8'h55);
    check({7'h00, addr_lsb}, 8'h01);
    check(8'(n_cmd + n_dat), 8'h00);
    check({7'h00, bus_if.data_bus[2]}, {7'h00, bus_if.data_bus[1]});
    xfer(1'b0, 1'b0, 8'h55);
    check({7'h00, addr_lsb}, 8'h00);
    $display("test serial and bus address done");
  endtask
  // Report and end the run
  task automatic wrap_up();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    t_modes();
    t_parallel(HBIS_STRAP_ENSTB);
    t_parallel(HBIS_STRAP_SEPSTB);
    t_clock_src();
    t_dev_reset();
    t_serial();
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
